// ===== hdl/can_xcvr_map.svh
`ifndef CAN_XCVR_MAP_SVH
`define CAN_XCVR_MAP_SVH

// system clock period in ns (125 MHz)
`define CLK_PERIOD_NS      8
// internal time base tick period in ns
`define TICK_PERIOD_NS     1000
// clock cycles per time base tick, rounded down, at least one
`define TICK_CYCLES        ((`TICK_PERIOD_NS / `CLK_PERIOD_NS) < 1 ? 1 : \
                            (`TICK_PERIOD_NS / `CLK_PERIOD_NS))
// width of the tick divider counter
`define TICK_CNT_W         8
// default dominant time-out in time base ticks
`define DOM_TIMEOUT_TICKS  1000
// width of the dominant time-out counter
`define DOM_CNT_W          16
// reset values of the line-side outputs
`define RST_RX_DATA        1'h1
`define RST_DRIVE_DOM      1'h0

`endif

// ===== hdl/can_xcvr_pkg.sv
`default_nettype none

package can_xcvr_pkg;

    // operating mode of the transceiver
    typedef enum logic [1:0] {
        mode_off,
        mode_normal,
        mode_silent,
        mode_unpowered
    } mode_type;

    // one control pin as seen from the controller side
    typedef struct packed {
        logic level;   // sampled level when driven
        logic driven;  // pin is actually driven by the outside
    } pin_type;

    // supply and thermal monitor results
    typedef struct packed {
        logic core_supply_ok;   // core supply above undervoltage level
        logic io_supply_ok;     // io supply above undervoltage level
        logic over_temp;        // junction above shutdown_temperature
    } health_type;

    // driver controls toward the bus lines
    typedef struct packed {
        logic bus_high_line_drive;  // pull high line up (dominant)
        logic bus_low_line_drive;   // pull low line down (dominant)
        logic bias_on;              // recessive bias present, not floating
    } bus_drive_type;

endpackage : can_xcvr_pkg

`default_nettype wire

// ===== hdl/dominant_timer.sv
`include "can_xcvr_map.svh"
`default_nettype none

module dominant_timer #(
    parameter logic [`DOM_CNT_W-1:0] LIMIT = `DOM_CNT_W'(`DOM_TIMEOUT_TICKS)
) (
    input  wire logic clock,
    input  wire logic resetn,
    input  wire logic tick,     // time base enable pulse
    input  wire logic run,      // transmit data held low
    output logic      expired   // low period exceeded the limit
);

    // all state of the timer
    typedef struct packed {
        logic [`DOM_CNT_W-1:0] count;
        logic                  expired;
    } timer_state_type;

    timer_state_type state_r;   // registered state
    timer_state_type state_nxt; // next state

    // count ticks while low, clear as soon as it goes high
    always_comb begin
        state_nxt = state_r;
        if (!run) begin
            // [RQ6] cleared and re-armed
            state_nxt.count   = '0;
            state_nxt.expired = 1'h0;
        end else if (tick && !state_r.expired) begin
            // [RQ5] low outlasted limit
            if (state_r.count >= LIMIT) begin
                state_nxt.expired = 1'h1;
            end else begin
                state_nxt.count = state_r.count + `DOM_CNT_W'(1);
            end
        end
    end

    // state register
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign expired = state_r.expired;

endmodule // dominant_timer

`default_nettype wire

// ===== hdl/can_xcvr.sv
// Contract
// [RQ1] enable high, silent low: transmit data drives bus
// [RQ2] silent high: transmitter off, bus recessive
// [RQ3] enable low: driver and receive output float
// [RQ4] receive output low dominant, high recessive
// [RQ5] long low transmit data releases the bus
// [RQ6] transmit data high clears the timer
// [RQ7] controller bit rate at least 20 kbit/s
// [RQ8] floating transmit high, silent and enable low
// [RQ9] either supply low: off, zero bus load
// [RQ10] overtemp off until cool and transmit high
// [RQ11] parameter removes enable, then always enabled
// [RQ12] time-out length is a tick-count parameter
`include "can_xcvr_map.svh"
`default_nettype none

module can_xcvr #(
    parameter bit                    HAS_ENABLE  = 1'h1,
    parameter logic [`DOM_CNT_W-1:0] DOM_TICKS   = `DOM_CNT_W'(`DOM_TIMEOUT_TICKS)
) (
    input  wire logic                       clock,
    input  wire logic                       resetn,
    input  wire can_xcvr_pkg::pin_type      tx_data,
    input  wire can_xcvr_pkg::pin_type      silent_sel,
    input  wire can_xcvr_pkg::pin_type      enable,
    input  wire can_xcvr_pkg::health_type   health,
    input  wire logic                       bus_dominant,
    output logic                            rx_data,
    output logic                            rx_data_oe,
    output can_xcvr_pkg::bus_drive_type     bus_drive,
    output can_xcvr_pkg::mode_type          mode
);
    import can_xcvr_pkg::*;

    // all state of the transceiver control
    // kept as one struct so reset and update stay in step
    typedef struct packed {
        mode_type                mode;        // current operating mode
        logic                    rx_data;     // receive data pin level
        logic                    rx_oe;       // receive data pin driven
        bus_drive_type           drive;       // bus driver controls
        logic                    ot_latched;  // thermal shutdown held
        logic [`TICK_CNT_W-1:0]  tick_cnt;    // time base divider
        logic                    tick;        // time base enable pulse
    } xcvr_state_type;

    xcvr_state_type state_r;    // registered state
    xcvr_state_type state_nxt;  // next state

    // pin levels after the fail-safe defaults
    logic txd_level;    // transmit data after fail-safe default
    logic silent_level; // silent select after fail-safe default
    logic en_level;     // enable after fail-safe default

    // protection status toward the driver
    logic supply_ok;    // both supplies above undervoltage
    logic dom_expired;  // dominant time-out has tripped
    logic tx_allowed;   // transmitter may drive dominant

    // fail-safe pin defaults and enable option
    // a pin not driven from outside reads as its pull level
    always_comb begin
        // [RQ8] pull-up on transmit data
        txd_level    = tx_data.driven ? tx_data.level : 1'h1;
        // [RQ8] pull-downs on silent select and enable
        silent_level = silent_sel.driven ? silent_sel.level : 1'h0;
        // [RQ11] absent enable reads as high
        if (HAS_ENABLE) begin
            // pin fitted: pull-down when left open
            en_level = enable.driven ? enable.level : 1'h0;
        end else begin
            // pin not fitted: never off
            en_level = 1'h1;
        end
    end

    // either supply missing drops the block to zero load
    // [RQ9] both supplies needed to operate
    assign supply_ok = health.core_supply_ok && health.io_supply_ok;

    // dominant time-out timer, runs while transmit data is low
    // it runs in every mode, so a low held through silent or off
    // is still counted when the transmitter comes back
    // clock, reset and tick are shared with this block
    // [RQ12] limit set in time base ticks
    dominant_timer #(
        .LIMIT   (DOM_TICKS)
    ) u_dom_timer (
        .clock   (clock),
        .resetn  (resetn),
        .tick    (state_r.tick),
        // [RQ5] started when transmit data falls
        .run     (!txd_level),
        .expired (dom_expired)
    );

    // transmitter may drive only with no fault holding it off
    // the bias stays on, so a cut transmitter leaves the bus recessive
    // [RQ5] time-out and thermal release
    assign tx_allowed = !dom_expired && !state_r.ot_latched;

    // next-state logic of the whole block
    always_comb begin
        // hold everything unless a branch below changes it
        state_nxt = state_r;

        // time base divider, one pulse per tick period
        // the tick is registered, so the timer sees it one clock late
        // the division truncates, so a tick may run slightly fast
        if (state_r.tick_cnt >= `TICK_CNT_W'(`TICK_CYCLES - 1)) begin
            // wrap and emit one tick
            state_nxt.tick_cnt = '0;
            state_nxt.tick     = 1'h1;
        end else begin
            // count toward the wrap
            state_nxt.tick_cnt = state_r.tick_cnt + `TICK_CNT_W'(1);
            state_nxt.tick     = 1'h0;
        end

        // waiting for recessive stops drift from toggling the drivers
        // thermal latch: set wins, clear needs cool and recessive
        // [RQ10] hold off until cool and high
        if (health.over_temp) begin
            // hot: hold the drivers off
            state_nxt.ot_latched = 1'h1;
        end else if (txd_level) begin
            // cool and recessive: release
            state_nxt.ot_latched = 1'h0;
        end

        // mode selection from supplies and control pins
        // priority: supplies, then enable, then silent select
        if (!supply_ok) begin
            // [RQ9] undervoltage overrides everything
            state_nxt.mode = mode_unpowered;
        end else if (!en_level) begin
            // [RQ3] enable low selects off
            state_nxt.mode = mode_off;
        end else if (silent_level) begin
            // [RQ2] silent select high
            state_nxt.mode = mode_silent;
        end else begin
            // [RQ1] silent select low
            state_nxt.mode = mode_normal;
        end

        // outputs follow the mode being entered
        // silent or cut transmitter keeps the bias; only off modes float
        unique case (state_nxt.mode)
            mode_normal: begin
                // both lines are driven together
                // [RQ1] dominant while low, recessive while high
                state_nxt.drive.bus_high_line_drive = !txd_level && tx_allowed;
                state_nxt.drive.bus_low_line_drive  = !txd_level && tx_allowed;
                state_nxt.drive.bias_on             = 1'h1;
                // [RQ4] receive output mirrors bus state
                state_nxt.rx_data                   = !bus_dominant;
                state_nxt.rx_oe                     = 1'h1;
            end

            mode_silent: begin
                // drivers stay off whatever transmit data does
                // [RQ2] transmitter off, receiver still active
                state_nxt.drive.bus_high_line_drive = 1'h0;
                state_nxt.drive.bus_low_line_drive  = 1'h0;
                state_nxt.drive.bias_on             = 1'h1;
                // [RQ4] receive output mirrors bus state
                state_nxt.rx_data                   = !bus_dominant;
                state_nxt.rx_oe                     = 1'h1;
            end

            mode_off: begin
                // off keeps the protection state, it is no reset
                // receive pin parked high behind its disabled driver
                // [RQ3] bus and receive output float
                state_nxt.drive                     = '0;
                state_nxt.rx_data                   = `RST_RX_DATA;
                state_nxt.rx_oe                     = 1'h0;
            end

            mode_unpowered: begin
                // bias off as well: no load on either line
                // [RQ9] zero load, nothing driven
                state_nxt.drive                     = '0;
                state_nxt.rx_data                   = `RST_RX_DATA;
                state_nxt.rx_oe                     = 1'h0;
            end
        endcase
    end

    // state register
    always_ff @(posedge clock) begin
        if (!resetn) begin
            // outputs as in off mode until released
            state_r.mode       <= mode_off;
            state_r.rx_data    <= `RST_RX_DATA;
            state_r.rx_oe      <= 1'h0;
            state_r.drive      <= '0;
            // protection and time base start clear
            state_r.ot_latched <= 1'h0;
            state_r.tick_cnt   <= '0;
            state_r.tick       <= 1'h0;
        end else begin
            // take the next state
            state_r <= state_nxt;
        end
    end

    // registered outputs
    // every output comes straight from a flip-flop, so pins never glitch
    // receive pin level
    assign rx_data    = state_r.rx_data;
    // receive pin driven
    assign rx_data_oe = state_r.rx_oe;
    // bus driver controls
    assign bus_drive  = state_r.drive;
    // current operating mode
    assign mode       = state_r.mode;

endmodule // can_xcvr

`default_nettype wire

// ===== tb/can_xcvr_chk.sv
`include "can_xcvr_map.svh"
`default_nettype none
module can_xcvr_chk #(
    parameter bit HAS_ENABLE = 1'h1,
    parameter int DOM_TICKS  = 3
) (
    input wire logic                        clock,
    input wire logic                        resetn,
    input wire can_xcvr_pkg::pin_type       tx_data,
    input wire can_xcvr_pkg::pin_type       silent_sel,
    input wire can_xcvr_pkg::pin_type       enable,
    input wire can_xcvr_pkg::health_type    health,
    input wire logic                        bus_dominant,
    input wire logic                        rx_data,
    input wire logic                        rx_data_oe,
    input wire can_xcvr_pkg::bus_drive_type bus_drive,
    input wire can_xcvr_pkg::mode_type      mode
);
    timeunit 1ns;
    timeprecision 1ns;
    import can_xcvr_pkg::*;
    // latest cycle a stuck low may still drive
    localparam int MAXC = (DOM_TICKS + 2) * `TICK_CYCLES + 4;
    logic        tx_hi;  // transmit read with pull-up
    logic        en_hi;  // enable read with pull-down
    logic        sil_hi; // silent read with pull-down
    logic        run;    // powered and enabled
    logic [15:0] low_r;  // cycles transmit held low
    assign tx_hi  = tx_data.level | ~tx_data.driven;
    assign en_hi  = HAS_ENABLE ? (enable.level & enable.driven) : 1'h1;
    assign sil_hi = silent_sel.level & silent_sel.driven;
    assign run    = health.core_supply_ok & health.io_supply_ok & en_hi;
    // saturating low-time counter
    always_ff @(posedge clock) begin
        if (!resetn || tx_hi) begin
            low_r <= 16'h0;
        end else if (low_r != 16'hFFFF) begin
            low_r <= low_r + 16'h1;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    a_undervolt_off: assert property (
        !(health.core_supply_ok & health.io_supply_ok) |=>
        mode == mode_unpowered && bus_drive == 3'h0 && !rx_data_oe) else $error("bus kept");
    a_enable_off: assert property (
        health.core_supply_ok && health.io_supply_ok && !en_hi |=>
        mode == mode_off && bus_drive == 3'h0 && !rx_data_oe) else $error("off mode wrong");
    a_silent_quiet: assert property (
        run && sil_hi |=> mode == mode_silent && bus_drive == 3'h1) else $error("silent drove");
    a_rx_follow: assert property (
        run |=> rx_data_oe && rx_data == !$past(bus_dominant)) else $error("rx wrong");
    a_normal_rec: assert property (
        run && !sil_hi && tx_hi |=> mode == mode_normal && bus_drive == 3'h1)
        else $error("not recessive");
    a_fall_dom: assert property (
        run && !sil_hi && !tx_hi && $past(tx_hi) && !health.over_temp &&
        !$past(health.over_temp) |=> bus_drive == 3'h7) else $error("not dominant");
    a_timeout_cut: assert property (
        low_r > MAXC |-> bus_drive[2:1] == 2'h0) else $error("time-out missed");
    a_thermal_off: assert property (
        health.over_temp |-> ##2 !bus_drive.bus_low_line_drive) else $error("hot drive");
    a_thermal_hold: assert property (
        $past(resetn) && $fell(health.over_temp) && !tx_hi |=>
        !bus_drive.bus_low_line_drive) else $error("thermal released early");
    // main scenarios reached
    c_dominant: cover property (bus_drive == 3'h7);
    c_silent: cover property (mode == mode_silent);
    c_timeout: cover property (low_r > MAXC);
endmodule // can_xcvr_chk

bind can_xcvr can_xcvr_chk #(.HAS_ENABLE(HAS_ENABLE), .DOM_TICKS(DOM_TICKS)) can_xcvr_chk_i (
    .clock(clock), .resetn(resetn), .tx_data(tx_data), .silent_sel(silent_sel),
    .enable(enable), .health(health), .bus_dominant(bus_dominant), .rx_data(rx_data),
    .rx_data_oe(rx_data_oe), .bus_drive(bus_drive), .mode(mode));
`default_nettype wire

// ===== tb/can_ctrl_model.sv
`default_nettype none
module can_ctrl_model (
    input  wire can_xcvr_pkg::pin_type tx_cmd,
    output var  can_xcvr_pkg::pin_type tx_data
);
    timeunit 1ns;
    timeprecision 1ns;
    import can_xcvr_pkg::*;
    // bench holds long lows to trip the time-out
    // released pin rises through its pull-up
    assign tx_data = '{level: tx_cmd.level | ~tx_cmd.driven, driven: tx_cmd.driven};
endmodule // can_ctrl_model
`default_nettype wire

// ===== tb/can_transceiver_mode_failsafe_test.sv
`default_nettype none
module can_transceiver_mode_failsafe_test;
    timeunit 1ns;
    timeprecision 1ns;
    import can_xcvr_pkg::*;
    logic          clock = 1'h0;  // 125 MHz
    logic          resetn = 1'h0; // sync, low active
    pin_type       tx_cmd, silent_sel, enable, tx_data;
    health_type    health;        // monitor levels
    logic          bus_dominant;  // receiver result
    logic          rx_data, rx_data_oe;
    bus_drive_type bus_drive;
    mode_type      mode, mode_noen;
    int            miscompares = 0, n_tests = 0;
    wire logic [6:0] outs = {mode, rx_data, rx_data_oe, bus_drive};
    // inputs {en,sil,tx,health,bus} beside outputs {mode,rx,oe,drive}
    logic [16:0] rows [13] = '{{10'h35D, 7'h2F}, {10'h37C, 7'h39}, {10'h34C, 7'h39},
        {10'h3DD, 7'h49}, {10'h39D, 7'h2F}, {10'h27D, 7'h10}, {10'h17D, 7'h10},
        {10'h375, 7'h70}, {10'h379, 7'h70}, {10'h37E, 7'h39}, {10'h35C, 7'h39},
        {10'h37C, 7'h39}, {10'h35D, 7'h2F}};
    always #4 clock = ~clock;
    can_ctrl_model can_ctrl_model_i (.tx_cmd(tx_cmd), .tx_data(tx_data));
    can_xcvr #(.DOM_TICKS(16'h3)) can_xcvr_i (.clock(clock), .resetn(resetn),
        .tx_data(tx_data), .silent_sel(silent_sel), .enable(enable), .health(health),
        .bus_dominant(bus_dominant), .rx_data(rx_data), .rx_data_oe(rx_data_oe),
        .bus_drive(bus_drive), .mode(mode));
    // build without an enable pin
    can_xcvr #(.HAS_ENABLE(1'h0), .DOM_TICKS(16'h3)) can_xcvr_noen_i (.clock(clock),
        .resetn(resetn), .tx_data(tx_data), .silent_sel(silent_sel), .enable(enable),
        .health(health), .bus_dominant(bus_dominant), .rx_data(), .rx_data_oe(),
        .bus_drive(), .mode(mode_noen));
    // compare and report
    task automatic check(input string name, input logic [6:0] seen, input logic [6:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // counts and verdict
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // hang guard, about 5000 cycles
    initial begin
        #40000;
        miscompares++;
        finish_test();
    end
    initial begin
        int n;
        {enable, silent_sel, tx_cmd, health, bus_dominant} = 10'h37C;
        repeat (5) @(negedge clock);
        check("reset outputs", outs, 7'h10);
        resetn = 1'h1;
        $display("reset test done");
        foreach (rows[i]) begin
            {enable, silent_sel, tx_cmd, health, bus_dominant} = rows[i][16:7];
            @(negedge clock);
            check($sformatf("row %0d", i), outs, rows[i][6:0]);
        end
        $display("table test done");
        enable = 2'h0;
        @(negedge clock);
        check("no enable pin", {5'h0, mode_noen}, {5'h0, mode_normal});
        check("floating enable", {5'h0, mode}, {5'h0, mode_off});
        enable = 2'h3;
        n = 0;
        @(negedge clock);
        while (bus_drive.bus_low_line_drive && n < 1000) begin
            @(negedge clock);
            n++;
        end
        check("timeout window", {6'h0, n >= 360 && n <= 640}, 7'h1);
        // bus stays released while the low goes on
        repeat (200) @(negedge clock);
        check("timeout held", outs, 7'h29);
        tx_cmd = 2'h3;
        @(negedge clock);
        tx_cmd = 2'h1;
        repeat (250) @(negedge clock);
        check("re-armed drive", outs, 7'h2F);
        resetn = 1'h0;
        @(negedge clock);
        check("mid reset", outs, 7'h10);
        resetn = 1'h1;
        // first edge after release drives again
        @(negedge clock);
        check("after reset", outs, 7'h2F);
        $display("timeout test done");
        finish_test();
    end
endmodule // can_transceiver_mode_failsafe_test
`default_nettype wire
